// ### core/dmc_defs.svh
// Register offsets, field positions, reset values, FIFO depth and synchroniser depth of the DMA data configuration block.
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_OFF_DATA_CONFIG   4'hE
`define DMC_OFF_XMIT_CONFIG   4'hD
`define DMC_OFF_RSA0          4'h8
`define DMC_OFF_RSA1          4'h9
`define DMC_BIT_WIDTH         0
`define DMC_BIT_ORDER         1
`define DMC_BIT_LONG          2
`define DMC_BIT_LOOPSEL       3
`define DMC_BIT_AUTO          4
`define DMC_BIT_FT_LO         5
`define DMC_BIT_FT_HI         6
`define DMC_BIT_LB_LO         1
`define DMC_BIT_LB_HI         2
`define DMC_DATA_CONFIG_RESET 7'h04
`define DMC_XMIT_CONFIG_RESET 2'h0
`define DMC_FIFO_BYTES        5'h10
`define DMC_PIN_SYNC_STAGES   3
`endif

// ### core/dmc_pkg.sv
// Types shared by the DMA data configuration block.
package dmc_pkg;
    typedef enum logic [1:0] {
        DMC_LOOP_NORMAL   = 2'b00,
        DMC_LOOP_INTERNAL = 2'b01,
        DMC_LOOP_EXT_PIN  = 2'b10,
        DMC_LOOP_EXT_NOPIN = 2'b11
    } dmc_loop_t;
    typedef enum logic [1:0] {
        DMC_DIR_IDLE = 2'b00,
        DMC_DIR_RECV = 2'b01,
        DMC_DIR_XMIT = 2'b10
    } dmc_dir_t;
endpackage

// ### core/dmc_pin_sync.sv
// Three-stage synchroniser for one pin input; a change counts once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module dmc_pin_sync (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic pin,
    output var  logic level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    // Shift the pin in; the first stage feeds only the second.
    always_comb begin
        next_stage = {stage[1:0], pin};
        next_level = (stage[2] == stage[1]) ? stage[1] : level;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule
`default_nettype wire

// ### core/dmc_lane_mux.sv
// Places a 16-bit memory word onto the data lanes for the selected width and byte order.
`timescale 1ns/1ns
`default_nettype none
module dmc_lane_mux (
    input  wire logic [15:0] word_in,
    input  wire logic        word_mode,
    input  wire logic        lane_swap,
    input  wire logic        addr_bit0,
    output logic [15:0]      lanes
);
    // Byte mode ignores the swap bit and puts the addressed byte on the lower lanes.
    always_comb begin
        if (!word_mode) begin
            lanes = {8'h00, addr_bit0 ? word_in[7:0] : word_in[15:8]}; // see RQ5
        end else if (lane_swap) begin
            lanes = {word_in[7:0], word_in[15:8]}; // see RQ4
        end else begin
            lanes = word_in; // see RQ4
        end
    end
endmodule
`default_nettype wire

// ### core/dmc_data_config.sv
// DMA data configuration register and the DMA addressing, lane, threshold and request logic it steers.
`timescale 1ns/1ns
`default_nettype none
`include "dmc_defs.svh"

// The block keeps the data configuration, the loop field of the transmit configuration and the
// remote start address, and turns them into width, lane, address, loopback and bus request behaviour.
// Limitations: the FIFO, the byte counters and the network side live elsewhere; this block only sees
// the fill level and the transfer strobes. The registers are write only and cannot be read back.
// Send-packet with swapped lane order is not refused here; keeping the two apart is up to the host.

// How it works
// RQ1: Transfer-width bit 0 gives byte DMA, 1 gives word DMA.
// RQ2: One width setting serves both remote and local DMA channels.
// RQ3: Word mode forces address bit 0 low, spanning 32k words.
// RQ4: Order bit 0 puts high byte on upper lanes; 1 swaps lanes.
// RQ5: Order bit is ignored in byte mode.
// RQ6: Long-address bit 0 gives two 16-bit channels; 1 gives 32-bit.
// RQ7: In 32-bit mode remote start address drives address bits 16 to 31.
// RQ8: Long-address bit resets to 1.
// RQ9: Loopback-select 0 enables loopback; host also programs transmit loop field.
// RQ10: Auto-init bit lets send-packet start remote DMA; otherwise command ignored.
// RQ11: Hosts using swapped byte order must not use send-packet.
// RQ12: Receive bus request at threshold 1/2/4/6 words or 2/4/8/12 bytes.
// RQ13: Transmit bus request at sixteen bytes minus receive threshold.
// RQ14: Burst length equals the programmed threshold.
// RQ15: Host writes configuration before loading remote byte counts.
// RQ16: Loop field picks mode; only code 10 drives loopback pin high.
// RQ17: Top configuration bit is ignored.
module dmc_data_config
    import dmc_pkg::*;
#(
    parameter logic [4:0] FIFO_BYTES = `DMC_FIFO_BYTES
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        send_packet_cmd,
    input  wire logic        recv_active,
    input  wire logic        xmit_active,
    input  wire logic [4:0]  fifo_bytes,
    input  wire logic        bus_ack_pin,
    input  wire logic        dma_strobe,
    input  wire logic        remote_sel,
    input  wire logic [15:0] local_addr,
    input  wire logic [15:0] remote_addr,
    input  wire logic [15:0] mem_word,
    output logic             bus_request,
    output logic [15:0]      dma_addr_lo,
    output logic [15:0]      dma_addr_hi,
    output logic             dma_addr_hi_en,
    output logic [7:0]       upper_data_lanes,
    output logic [7:0]       lower_data_lanes,
    output logic             word_transfer,
    output logic             loopback_active,
    output logic             loopback_out_pin,
    output logic             remote_auto_start,
    output logic [3:0]       burst_remaining
);
    // A FIFO no deeper than the largest receive level would leave no transmit level at all.
    if (FIFO_BYTES <= 5'h0C) begin : g_fifo_depth_check
        $error("FIFO depth must exceed the largest receive threshold.");
    end
    // Word mode counts two bytes per word, so an odd depth would leave half a word unusable.
    if (FIFO_BYTES[0]) begin : g_fifo_even_check
        $error("FIFO depth must be an even number of bytes.");
    end

    // Stored registers and their next values.
    logic [6:0]  dma_data_config;
    logic [1:0]  transmit_config;
    logic [15:0] remote_start_address;
    logic [6:0]  next_config;
    logic [1:0]  next_xmit;
    logic [15:0] next_rsa;

    // One wire per configuration bit, named for what it does.
    logic transfer_width_select;
    logic byte_lane_order;
    logic long_address_select;
    logic loopback_select;
    logic auto_remote_init;
    logic fifo_threshold_lo;
    logic fifo_threshold_hi;
    logic loop_mode_lo;
    logic loop_mode_hi;

    // Field decode from the stored registers.
    assign transfer_width_select = dma_data_config[`DMC_BIT_WIDTH];
    assign byte_lane_order       = dma_data_config[`DMC_BIT_ORDER];
    assign long_address_select   = dma_data_config[`DMC_BIT_LONG];
    assign loopback_select       = dma_data_config[`DMC_BIT_LOOPSEL];
    assign auto_remote_init      = dma_data_config[`DMC_BIT_AUTO];
    assign fifo_threshold_lo     = dma_data_config[`DMC_BIT_FT_LO];
    assign fifo_threshold_hi     = dma_data_config[`DMC_BIT_FT_HI];
    assign loop_mode_lo          = transmit_config[0];
    assign loop_mode_hi          = transmit_config[1];

    // Register writes. Bit 7 of the data configuration is simply not stored, so a host that sets it
    // sees no effect. Nothing here can be read back, so software that wants to change one field at a
    // time must keep its own copy of the whole byte.
    always_comb begin
        next_config = dma_data_config;
        next_xmit   = transmit_config;
        next_rsa    = remote_start_address;
        // Hold everything by default; only the addressed register takes the new byte.
        if (reg_write) begin
            unique case (reg_addr)
                `DMC_OFF_DATA_CONFIG: next_config = reg_wdata[6:0]; // see RQ17
                `DMC_OFF_XMIT_CONFIG: next_xmit = reg_wdata[`DMC_BIT_LB_HI:`DMC_BIT_LB_LO];
                `DMC_OFF_RSA0:        next_rsa = {remote_start_address[15:8], reg_wdata};
                `DMC_OFF_RSA1:        next_rsa = {reg_wdata, remote_start_address[7:0]};
                default:              next_config = dma_data_config;
            endcase
        end
    end

    // Long address comes up set so 32-bit addressing is the default.
    // The loop field comes up at normal operation, so a fresh device leaves the loopback pin low.
    // The remote start address comes up zero; a host that uses 32-bit mode writes it first.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dma_data_config      <= `DMC_DATA_CONFIG_RESET; // see RQ8
            transmit_config      <= `DMC_XMIT_CONFIG_RESET;
            remote_start_address <= 16'h0000;
        end else begin
            dma_data_config      <= next_config;
            transmit_config      <= next_xmit;
            remote_start_address <= next_rsa;
        end
    end

    // The bus grant comes from another party, so it is synchronised. The grant is seen three to four
    // clocks after the pin rises; strobes before that are not counted, which costs latency but never
    // lets a transfer be counted against a grant that has not settled.
    logic bus_ack;
    dmc_pin_sync u_ack_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pin     (bus_ack_pin),
        .level   (bus_ack)
    );

    // Threshold in bytes; word mode counts two bytes per word, so one table serves both widths.
    // The transmit level is what is left of the FIFO once the receive level is taken out.
    logic [4:0] recv_thresh;
    logic [4:0] xmit_thresh;
    logic [3:0] burst_units;
    always_comb begin
        // Codes 00 to 11 give 2, 4, 8 and 12 bytes.
        unique case ({fifo_threshold_hi, fifo_threshold_lo})
            2'b00: recv_thresh = 5'h02; // see RQ12
            2'b01: recv_thresh = 5'h04;
            2'b10: recv_thresh = 5'h08;
            2'b11: recv_thresh = 5'h0C;
        endcase
        xmit_thresh = FIFO_BYTES - recv_thresh; // see RQ13
        // One burst moves the threshold's worth of bytes, halved when words move.
        // Burst length is fixed when the request goes up; a later threshold write waits for the next burst.
        burst_units = transfer_width_select ? recv_thresh[4:1] : recv_thresh[3:0]; // see RQ14
    end

    // Request and burst sequencing. In idle, reception is looked at first, so a receive FIFO that
    // reaches its level is never starved by a transmit refill. Once the request is up it stays up until
    // the burst count has been run down by strobes under a settled grant; the FIFO level is not looked
    // at in the meantime, so a burst always has the programmed length even if the fill moves.
    // The request drops for at least one clock between bursts, which lets the bus owner rearbitrate.
    dmc_dir_t   dir;
    dmc_dir_t   next_dir;
    logic [3:0] next_burst;
    logic       next_bus_request;
    logic       fifo_empty_room;
    // The fill level comes from logic on this clock, so it is used without synchronising.
    // A fill count above the depth is taken as no room at all rather than wrapping round.
    assign fifo_empty_room = (fifo_bytes <= FIFO_BYTES) && ((FIFO_BYTES - fifo_bytes) >= xmit_thresh);
    always_comb begin
        next_dir   = dir;
        next_burst = burst_remaining;
        next_bus_request  = bus_request;
        unique case (dir)
            DMC_DIR_IDLE: begin
                // Idle: wait for a level to be crossed.
                if (recv_active && fifo_bytes >= recv_thresh) begin
                    next_dir   = DMC_DIR_RECV; // see RQ12
                    next_bus_request  = 1'b1;
                    next_burst = burst_units;
                end else if (xmit_active && fifo_empty_room) begin
                    // Room for the transmit threshold means local DMA filling can begin.
                    next_dir   = DMC_DIR_XMIT; // see RQ13
                    next_bus_request  = 1'b1;
                    next_burst = burst_units;
                end
            end
            DMC_DIR_RECV, DMC_DIR_XMIT: begin
                // Busy: count strobes that arrive under a settled grant.
                if (bus_ack && dma_strobe) begin
                    next_burst = burst_remaining - 4'h1; // see RQ14
                    if (burst_remaining == 4'h1) begin
                        next_dir  = DMC_DIR_IDLE;
                        next_bus_request = 1'b0;
                    end
                end
            end
            default: begin
                // An unused state code returns to idle with the request down.
                next_dir  = DMC_DIR_IDLE;
                next_bus_request = 1'b0;
            end
        endcase
    end

    // Request state registers; the request output comes straight from its flop.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dir             <= DMC_DIR_IDLE;
            burst_remaining <= 4'h0;
            bus_request     <= 1'b0;
        end else begin
            dir             <= next_dir;
            burst_remaining <= next_burst;
            bus_request     <= next_bus_request;
        end
    end

    // Address and lane formation; one width bit serves both channels. The channel address is taken
    // as given and only bit 0 is masked in word mode, so a word access never straddles two words and
    // word addressing covers 32k words. The lane and address outputs lag their inputs by one clock.
    logic [15:0] sel_addr;
    logic [15:0] lanes;
    logic [15:0] next_addr_lo;
    logic [15:0] next_addr_hi;
    logic        next_hi_en;
    // Lane placement is shared by both channels; the width and order bits and address bit 0 steer it.
    dmc_lane_mux u_lanes (
        .word_in   (mem_word),
        .word_mode (transfer_width_select), // see RQ1
        .lane_swap (byte_lane_order),
        .addr_bit0 (sel_addr[0]),
        .lanes     (lanes)
    );
    always_comb begin
        // The channel select picks which address the shared lanes and the lower address output follow.
        sel_addr     = remote_sel ? remote_addr : local_addr; // see RQ2
        next_addr_lo = {sel_addr[15:1], sel_addr[0] & ~transfer_width_select}; // see RQ3
        // Dual mode leaves the upper half undriven so each channel stays 16 bits.
        next_hi_en   = long_address_select && bus_ack; // see RQ6
        // The upper half carries the start address even between grants; only the enable marks it valid.
        next_addr_hi = long_address_select ? remote_start_address : 16'h0000; // see RQ7
    end

    // Loopback: the pin is high only in external mode code 10. The pin follows the loop field alone,
    // so the transceiver side is switched even while the select bit still asks for normal operation;
    // the host is expected to set both before any traffic.
    logic next_loop_active;
    logic next_loop_pin;
    logic next_auto;
    always_comb begin
        // Loopback needs both the select bit low and a loop field other than normal.
        next_loop_active = !loopback_select && ({loop_mode_hi, loop_mode_lo} != DMC_LOOP_NORMAL); // see RQ9
        next_loop_pin    = ({loop_mode_hi, loop_mode_lo} == DMC_LOOP_EXT_PIN); // see RQ16
        // Send-packet is dropped unless auto-init is set.
        next_auto        = send_packet_cmd && auto_remote_init; // see RQ10
    end

    // Address outputs; the upper half is only enabled while a settled grant is held.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dma_addr_lo    <= 16'h0000;
            dma_addr_hi    <= 16'h0000;
            dma_addr_hi_en <= 1'b0;
        end else begin
            dma_addr_lo    <= next_addr_lo;
            dma_addr_hi    <= next_addr_hi;
            dma_addr_hi_en <= next_hi_en;
        end
    end

    // Data lanes and the width flag move together, so the lanes never disagree with the flag.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            upper_data_lanes <= 8'h00;
            lower_data_lanes <= 8'h00;
            word_transfer    <= 1'b0;
        end else begin
            upper_data_lanes <= lanes[15:8];
            lower_data_lanes <= lanes[7:0];
            word_transfer    <= transfer_width_select; // see RQ1
        end
    end

    // Mode flags and the auto start, which follows the gated command one clock later for as long as it is held.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loopback_active   <= 1'b0;
            loopback_out_pin  <= 1'b0;
            remote_auto_start <= 1'b0;
        end else begin
            loopback_active   <= next_loop_active;
            loopback_out_pin  <= next_loop_pin;
            remote_auto_start <= next_auto;
        end
    end
endmodule
`default_nettype wire

// ### dv/dmc_data_config_checker.sv
// Port checks for the DMA data configuration block.
`timescale 1ns/1ns
`default_nettype none
module dmc_data_config_checker (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        send_packet_cmd,
    input wire logic        recv_active,
    input wire logic        xmit_active,
    input wire logic        dma_strobe,
    input wire logic        bus_request,
    input wire logic [15:0] dma_addr_lo,
    input wire logic [7:0]  upper_data_lanes,
    input wire logic        word_transfer,
    input wire logic        loopback_out_pin,
    input wire logic        remote_auto_start,
    input wire logic [3:0]  burst_remaining
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Configuration outputs move only when a write named their register two clocks earlier.
    property p_word; $changed(word_transfer) |-> $past(reg_write, 2) && $past(reg_addr, 2) == 4'hE
        && $past(reg_wdata[0], 2) == word_transfer; endproperty
    a_word: assert property (p_word) else $error("Width flag moved without a matching write.");
    property p_pin; $changed(loopback_out_pin) |-> $past(reg_write, 2) && $past(reg_addr, 2) == 4'hD
        && ($past(reg_wdata[2:1], 2) == 2'b10) == loopback_out_pin; endproperty
    a_pin: assert property (p_pin) else $error("Loop pin moved without a write.");
    // Lane and address shaping; one cycle of slack lets a width change settle.
    property p_addr0; word_transfer && $past(word_transfer) |-> !dma_addr_lo[0]; endproperty
    a_addr0: assert property (p_addr0) else $error("Address bit zero high in word mode.");
    property p_byteup; !word_transfer && $past(!word_transfer) |-> upper_data_lanes == 8'h00; endproperty
    a_byteup: assert property (p_byteup) else $error("Upper lanes busy in byte mode.");
    property p_auto; remote_auto_start |-> $past(send_packet_cmd); endproperty
    a_auto: assert property (p_auto) else $error("Auto start without a command.");
    // A request needs a cause and opens a burst of a legal length that only strobes shorten.
    property p_burst; $rose(bus_request) |-> $past(recv_active || xmit_active)
        && burst_remaining inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC}; endproperty
    a_burst: assert property (p_burst) else $error("Bad request start.");
    property p_hold; bus_request && burst_remaining != 4'h0 && !dma_strobe |=> bus_request; endproperty
    a_hold: assert property (p_hold) else $error("Request dropped mid burst.");
    property p_count; bus_request && $past(bus_request) && $changed(burst_remaining) |-> $past(dma_strobe);
    endproperty
    a_count: assert property (p_count) else $error("Burst count moved without a strobe.");
endmodule
bind dmc_data_config dmc_data_config_checker i_chk (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write,
    .send_packet_cmd, .recv_active, .xmit_active, .dma_strobe, .bus_request, .dma_addr_lo, .upper_data_lanes,
    .word_transfer, .loopback_out_pin, .remote_auto_start, .burst_remaining);
`default_nettype wire

// ### dv/dmc_bus_host.sv
// Model of the system bus owner that grants the bus and paces DMA strobes.
`timescale 1ns/1ns
`default_nettype none
module dmc_bus_host (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       bus_request,
    input  wire logic [3:0] grant_delay,
    output logic            bus_ack_pin,
    output logic            dma_strobe,
    output int              strobe_count
);
    int wait_cnt;
    // Strobes wait out the pin synchroniser, since earlier ones would be dropped; every other cycle.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {bus_ack_pin, dma_strobe} <= 2'b00;
            wait_cnt <= 0;
            strobe_count <= 0;
        end else if (!bus_request) begin
            {bus_ack_pin, dma_strobe} <= 2'b00;
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
            bus_ack_pin <= wait_cnt >= grant_delay;
            dma_strobe <= wait_cnt >= grant_delay + 5 && !dma_strobe;
            strobe_count <= (wait_cnt == 0) ? 0 : strobe_count + int'(dma_strobe);
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the DMA data configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "dmc_defs.svh"
module tb_top;
    logic        clk_sys, reset_n, reg_write, send_packet_cmd, recv_active, xmit_active, remote_sel;
    logic [3:0]  reg_addr, grant_delay, burst_remaining;
    logic [7:0]  reg_wdata, upper_data_lanes, lower_data_lanes, hi_byte, lo_byte;
    logic [4:0]  fifo_bytes;
    logic [15:0] local_addr, remote_addr, mem_word, dma_addr_lo, dma_addr_hi, exp_addr, lanes;
    logic        bus_ack_pin, dma_strobe, bus_request, dma_addr_hi_en, word_transfer;
    logic        loopback_active, loopback_out_pin, remote_auto_start;
    int          failures, num_checks, strobe_count;
    assign lanes = {upper_data_lanes, lower_data_lanes};
    dmc_data_config i_dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write, .send_packet_cmd, .recv_active,
        .xmit_active, .fifo_bytes, .bus_ack_pin, .dma_strobe, .remote_sel, .local_addr, .remote_addr, .mem_word,
        .bus_request, .dma_addr_lo, .dma_addr_hi, .dma_addr_hi_en, .upper_data_lanes, .lower_data_lanes,
        .word_transfer, .loopback_active, .loopback_out_pin, .remote_auto_start, .burst_remaining);
    dmc_bus_host i_host (.clk_sys, .reset_n, .bus_request, .grant_delay, .bus_ack_pin, .dma_strobe, .strobe_count);
    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        @(negedge clk_sys);
        reg_write = 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wait_low();
        for (int n = 0; n < 100 && bus_request !== 1'b0; n++) cyc(1);
        check(bus_request, 1'b0);
    endtask
    // Receive level in bytes; the same in both widths, so word bursts count half as many units.
    function automatic logic [4:0] thr(input logic [1:0] c);
        thr = (c == 2'b11) ? 5'h0C : 5'h02 << c;
    endfunction
    // Main sequence; the host always configures before starting traffic.
    initial begin
        {reset_n, reg_write, reg_addr, reg_wdata, send_packet_cmd, recv_active, xmit_active} = '0;
        {fifo_bytes, remote_sel, local_addr, remote_addr, mem_word, grant_delay, failures, num_checks} = '0;
        void'($urandom(97964));
        cyc(16);
        reset_n = 1'b1;
        hi_byte = 8'($urandom);
        lo_byte = 8'($urandom);
        wr(`DMC_OFF_RSA0, lo_byte);
        wr(`DMC_OFF_RSA1, hi_byte);
        cyc(3);
        check(dma_addr_hi, {hi_byte, lo_byte});
        wr(`DMC_OFF_DATA_CONFIG, 8'h08);
        cyc(3);
        check(dma_addr_hi, 16'h0000);
        // Every width, order and byte address, on either channel, with the unused top bit both clear and set.
        for (int i = 0; i < 16; i++) begin
            wr(`DMC_OFF_DATA_CONFIG, {i[3], 4'b0001, 1'b1, i[1:0]});
            mem_word = 16'($urandom);
            local_addr = {15'($urandom), i[2]};
            remote_addr = {15'($urandom), i[2]};
            remote_sel = 1'($urandom);
            exp_addr = remote_sel ? remote_addr : local_addr;
            cyc(3);
            check(word_transfer, i[0]);
            check(dma_addr_lo, exp_addr & {15'h7FFF, !i[0]});
            if (i[0]) check(lanes, i[1] ? {mem_word[7:0], mem_word[15:8]} : mem_word);
            else check(lanes, {8'h00, i[2] ? mem_word[7:0] : mem_word[15:8]});
        end
        // Each threshold code in both widths: one byte short, then at the level, with a random grant delay.
        for (int i = 0; i < 8; i++) begin
            wr(`DMC_OFF_DATA_CONFIG, {1'b0, i[2:1], 4'b0110, i[0]});
            grant_delay = 4'($urandom_range(0, 9));
            recv_active = 1'b1;
            fifo_bytes = thr(i[2:1]) - 5'h01;
            cyc(3);
            check(bus_request, 1'b0);
            fifo_bytes = thr(i[2:1]);
            cyc(1);
            check(bus_request, 1'b1);
            {recv_active, fifo_bytes} = '0;
            // The synchronised grant lifts the upper address enable before the first strobe counts.
            cyc(int'(grant_delay) + 6);
            check(dma_addr_hi_en, 1'b1);
            wait_low();
            check(16'(strobe_count), i[0] ? thr(i[2:1]) >> 1 : thr(i[2:1]));
        end
        // Transmit needs room for the transmit level: nine bytes held is too many at an eight byte level.
        wr(`DMC_OFF_DATA_CONFIG, 8'h4C);
        {xmit_active, fifo_bytes} = {1'b1, 5'h09};
        cyc(3);
        check(bus_request, 1'b0);
        fifo_bytes = 5'h08;
        cyc(1);
        check(bus_request, 1'b1);
        xmit_active = 1'b0;
        wait_low();
        check(16'(strobe_count), 16'h0008);
        // All loop field codes against both loopback select values.
        for (int i = 0; i < 8; i++) begin
            wr(`DMC_OFF_XMIT_CONFIG, {5'h00, i[1:0], 1'b0});
            wr(`DMC_OFF_DATA_CONFIG, {4'h0, i[2], 3'b100});
            cyc(2);
            check(loopback_out_pin, i[1:0] == 2'b10);
            check(loopback_active, !i[2] && i[1:0] != 2'b00);
        end
        // Send-packet with straight byte order only; the auto bit decides whether it acts.
        for (int i = 0; i < 2; i++) begin
            wr(`DMC_OFF_DATA_CONFIG, {3'h0, i[0], 4'hC});
            send_packet_cmd = 1'b1;
            cyc(1);
            send_packet_cmd = 1'b0;
            check(remote_auto_start, i[0]);
            cyc(1);
            check(remote_auto_start, 1'b0);
        end
        test_done();
    end
    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        #200000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
